// ==== ric_consts.vh ====
// Purpose: shared offsets, field layout, reset values and timing counts
// Assumes: 32-bit register words, byte addresses on AXI4-Lite
// Notes:   included by the controller top and its arbiter
`ifndef RIC_CONSTS_VH
`define RIC_CONSTS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define RIC_OFS_FLAG      8'h00
`define RIC_OFS_MASK      8'h04
`define RIC_OFS_PRIO_LO   8'h08
`define RIC_OFS_PRIO_HI   8'h0C
`define RIC_OFS_RISE      8'h10
`define RIC_OFS_FALL      8'h14
`define RIC_OFS_KEY_EN    8'h18
`define RIC_OFS_CTRL      8'h1C
`define RIC_OFS_CAUSE     8'h20
`define RIC_OFS_CAUSE_EN  8'h24
`define RIC_OFS_STATUS    8'h28

// ----------------------------------------
// reset values
// ----------------------------------------
`define RIC_RST_MASK      16'hFFFF
`define RIC_RST_PRIO      16'hFFFF
`define RIC_RST_EDGE      8'h00
`define RIC_RST_CTRL      1'b0

// ----------------------------------------
// reset cause field positions
// ----------------------------------------
`define RIC_CAUSE_PIN     0
`define RIC_CAUSE_WDT     1
`define RIC_CAUSE_VOLT    2
`define RIC_CAUSE_ILLOP   3
`define RIC_CAUSE_PARITY  4
`define RIC_CAUSE_ACCESS  5
`define RIC_CAUSE_W       6

// ----------------------------------------
// codes and timing
// ----------------------------------------
`define RIC_ILLEGAL_OPCODE 8'hFF
`define RIC_RESP_MIN_CLK  9
`define RIC_RESP_MAX_CLK  16
`define RIC_RST_HOLD_CLK  16
`define RIC_LVL_NONE      3'h4
`define RIC_RESP_OKAY     2'h0
`define RIC_RESP_SLVERR   2'h2

`endif

// ==== ric_sync.v ====
// Purpose: three-flop pin synchroniser with agreement filter
// Assumes: inputs asynchronous to aclk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
`default_nettype none

module ric_sync #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // pins
  input  wire [W-1:0] pin_in,
  // filtered level
  output reg  [W-1:0] level_ff
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_ff[g]    <= INIT[g];
          s2_ff[g]    <= INIT[g];
          s3_ff[g]    <= INIT[g];
          level_ff[g] <= INIT[g];
        end else begin
          s1_ff[g] <= pin_in[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          // s1 is seen only by s2
          if (s2_ff[g] == s3_ff[g]) begin
            level_ff[g] <= s3_ff[g];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ==== ric_arb.v ====
// Purpose: pick the pending request with the best level
// Assumes: level 0 is highest, 3 lowest
// Notes:   ties go to the lowest source index (default order)
`include "ric_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module ric_arb #(
  parameter N  = 16,
  parameter IW = 4
) (
  // requests and levels
  input  wire [N-1:0]  req,
  input  wire [N-1:0]  lvl_hi,
  input  wire [N-1:0]  lvl_lo,
  // winner
  output reg           found,
  output reg  [IW-1:0] win_idx,
  output reg  [2:0]    win_lvl
);

  integer i;

  always @* begin
    found   = 1'b0;
    win_idx = {IW{1'b0}};
    win_lvl = `RIC_LVL_NONE;
    // descending walk with <= lets lower index win a tie
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i] && ({1'b0, lvl_hi[i], lvl_lo[i]} <= win_lvl)) begin
        found   = 1'b1;
        win_idx = i[IW-1:0];
        win_lvl = {1'b0, lvl_hi[i], lvl_lo[i]};
      end
    end
  end

endmodule

`default_nettype wire

// ==== ric_top.v ====
// Purpose: reset source collection and maskable interrupt controller
// Assumes: single clock aclk, software access over AXI4-Lite
// Notes:   sources 0..NEXT-1 pin edges, NEXT key return, rest internal
//
// Contract
// - External reset pin asserted puts the system into reset.
// - Watchdog loop detection causes internal reset.
// - Power-on or voltage detector supply drop causes internal reset.
// - Executing opcode FFH is illegal and causes internal reset.
// - Illegal opcode reset suppressed while emulator is active.
// - RAM read parity error causes internal reset.
// - Access to a forbidden memory region causes internal reset.
// - Four priority levels, two bits per source in two register groups.
// - Servicing starts 9 to 16 clocks after acceptance.
// - One request flag per source, readable and clearable by software.
// - One mask bit per source; set mask blocks acknowledge.
// - Rising and falling edge enable groups per external pin.
// - External pin edges raise external requests.
// - Key return detection raises an external request.
// - Equal priority ties resolved by fixed default order.
// - Higher priority preempts a lower priority service in progress.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "ric_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module ric_top #(
  parameter NEXT     = 6,
  parameter NKEY     = 8,
  parameter NINT     = 9,
  parameter RST_HOLD = `RIC_RST_HOLD_CLK,
  parameter RESP_CYC = `RIC_RESP_MIN_CLK
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // axi4-lite read data
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  // reset causes
  input  wire        reset_pin_n,
  input  wire        wdt_loop,
  input  wire        por_detect,
  input  wire        voltage_detector,
  input  wire        opcode_fetch,
  input  wire [7:0]  opcode,
  input  wire        emu_active,
  input  wire        ram_read,
  input  wire        ram_parity_err,
  input  wire        illegal_access,
  // interrupt sources
  input  wire [NEXT-1:0] ext_int_pin,
  input  wire [NKEY-1:0] key_pin,
  input  wire [NINT-1:0] int_src,
  // cpu side
  input  wire        cpu_reti,
  output wire        sys_reset,
  output wire        svc_start,
  output wire [3:0]  svc_vector,
  output wire [1:0]  svc_level,
  output wire        irq
);

  localparam N = NEXT + 1 + NINT;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg  [N-1:0]  request_flag_bit_ff;
  reg  [N-1:0]  source_mask_bit_ff;
  reg  [N-1:0]  priority_low_bit_ff;
  reg  [N-1:0]  priority_high_bit_ff;
  reg  [NEXT-1:0] rising_edge_enable_reg_ff;
  reg  [NEXT-1:0] falling_edge_enable_reg_ff;
  reg  [NKEY-1:0] key_enable_ff;
  reg           glob_en_ff;
  reg  [`RIC_CAUSE_W-1:0] cause_ff;
  reg  [`RIC_CAUSE_W-1:0] cause_en_ff;
  reg           irq_ff;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire          rpin_n_s;
  wire [NEXT+NKEY-1:0] pins_s;
  reg  [NEXT-1:0] ext_prev_ff;
  reg  [NKEY-1:0] key_prev_ff;

  ric_sync #(.W(1), .INIT(1'b1)) u_rst_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (reset_pin_n),
    .level_ff (rpin_n_s)
  );

  ric_sync #(.W(NEXT + NKEY), .INIT({(NEXT + NKEY){1'b1}})) u_pin_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   ({key_pin, ext_int_pin}),
    .level_ff (pins_s)
  );

  wire [NEXT-1:0] ext_s = pins_s[NEXT-1:0];
  wire [NKEY-1:0] key_s = pins_s[NEXT+NKEY-1:NEXT];

  // ----------------------------------------
  // reset sources
  // ----------------------------------------
  wire [`RIC_CAUSE_W-1:0] cause_hit;
  reg  [4:0]    rst_cnt_ff;
  reg           sys_reset_ff;

  assign cause_hit[`RIC_CAUSE_PIN]    = ~rpin_n_s;
  assign cause_hit[`RIC_CAUSE_WDT]    = wdt_loop;
  assign cause_hit[`RIC_CAUSE_VOLT]   = por_detect | voltage_detector;
  assign cause_hit[`RIC_CAUSE_ILLOP]  = opcode_fetch & ~emu_active &
                                        (opcode == `RIC_ILLEGAL_OPCODE);
  assign cause_hit[`RIC_CAUSE_PARITY] = ram_read & ram_parity_err;
  assign cause_hit[`RIC_CAUSE_ACCESS] = illegal_access;

  // reset stretched so short pulses still clear the system
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_ff <= 1'b1;
      rst_cnt_ff   <= 5'h00;
    end else if (|cause_hit) begin
      sys_reset_ff <= 1'b1;
      rst_cnt_ff   <= RST_HOLD[4:0];
    end else if (rst_cnt_ff != 5'h00) begin
      rst_cnt_ff   <= rst_cnt_ff - 5'h01;
    end else begin
      sys_reset_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // request events
  // ----------------------------------------
  wire [N-1:0] evt;
  assign evt[NEXT-1:0] = (ext_s & ~ext_prev_ff & rising_edge_enable_reg_ff) |
                         (~ext_s & ext_prev_ff & falling_edge_enable_reg_ff);
  // key return on any enabled key falling
  assign evt[NEXT] = |(~key_s & key_prev_ff & key_enable_ff);
  assign evt[N-1:NEXT+1] = int_src;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ext_prev_ff <= {NEXT{1'b1}};
      key_prev_ff <= {NKEY{1'b1}};
    end else begin
      ext_prev_ff <= ext_s;
      key_prev_ff <= key_s;
    end
  end

  // ----------------------------------------
  // arbitration and service
  // ----------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  wire         found;
  wire [3:0]   win_idx;
  wire [2:0]   win_lvl;
  reg          state_ff;
  reg  [4:0]   wait_ff;
  reg  [3:0]   isr_ff;
  reg  [2:0]   cur_lvl;
  reg          svc_start_ff;
  reg  [3:0]   svc_vector_ff;
  reg  [1:0]   svc_level_ff;
  reg  [N-1:0] ack_clr;

  // default order on ties; masked sources excluded
  ric_arb #(.N(N), .IW(4)) u_arb (
    .req     (request_flag_bit_ff & ~source_mask_bit_ff),
    .lvl_hi  (priority_high_bit_ff),
    .lvl_lo  (priority_low_bit_ff),
    .found   (found),
    .win_idx (win_idx),
    .win_lvl (win_lvl)
  );

  // best level now in service
  always @* begin
    cur_lvl = `RIC_LVL_NONE;
    if (isr_ff[3]) cur_lvl = 3'h3;
    if (isr_ff[2]) cur_lvl = 3'h2;
    if (isr_ff[1]) cur_lvl = 3'h1;
    if (isr_ff[0]) cur_lvl = 3'h0;
  end

  // only a strictly better level may nest
  wire accept = glob_en_ff & found & (win_lvl < cur_lvl) & (state_ff == ST_IDLE);

  always @(posedge aclk) begin
    if (!aresetn) begin
      state_ff      <= ST_IDLE;
      wait_ff       <= 5'h00;
      isr_ff        <= 4'h0;
      svc_start_ff  <= 1'b0;
      svc_vector_ff <= 4'h0;
      svc_level_ff  <= 2'h0;
    end else begin
      svc_start_ff <= 1'b0;
      if (cpu_reti && state_ff == ST_IDLE) begin
        isr_ff <= isr_ff & (isr_ff - 4'h1);
      end
      case (state_ff)
        ST_IDLE: begin
          if (accept) begin
            state_ff      <= ST_WAIT;
            wait_ff       <= RESP_CYC[4:0] - 5'h01;
            svc_vector_ff <= win_idx;
            svc_level_ff  <= win_lvl[1:0];
          end
        end
        ST_WAIT: begin
          if (wait_ff == 5'h01) begin
            state_ff     <= ST_IDLE;
            svc_start_ff <= 1'b1;
            isr_ff       <= isr_ff | (4'h1 << svc_level_ff);
          end
          wait_ff <= wait_ff - 5'h01;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // flag cleared when its service is committed
  always @* begin
    ack_clr = {N{1'b0}};
    if (accept) ack_clr[win_idx] = 1'b1;
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  reg         awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg         aw_held_ff, w_held_ff;
  reg  [7:0]  awaddr_ff;
  reg  [31:0] wdata_ff;
  reg  [3:0]  wstrb_ff;
  reg  [1:0]  bresp_ff, rresp_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] rd_val;
  reg         rd_ok, wr_ok;

  wire do_wr = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire do_rd = s_axi_arvalid & arready_ff;
  wire [31:0] bmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                       {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] wbits = wdata_ff & bmask;

  always @* begin
    wr_ok = 1'b1;
    case (awaddr_ff)
      `RIC_OFS_FLAG, `RIC_OFS_MASK, `RIC_OFS_PRIO_LO, `RIC_OFS_PRIO_HI,
      `RIC_OFS_RISE, `RIC_OFS_FALL, `RIC_OFS_KEY_EN, `RIC_OFS_CTRL,
      `RIC_OFS_CAUSE_EN: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    case (s_axi_araddr)
      `RIC_OFS_FLAG:     rd_val[N-1:0]    = request_flag_bit_ff;
      `RIC_OFS_MASK:     rd_val[N-1:0]    = source_mask_bit_ff;
      `RIC_OFS_PRIO_LO:  rd_val[N-1:0]    = priority_low_bit_ff;
      `RIC_OFS_PRIO_HI:  rd_val[N-1:0]    = priority_high_bit_ff;
      `RIC_OFS_RISE:     rd_val[NEXT-1:0] = rising_edge_enable_reg_ff;
      `RIC_OFS_FALL:     rd_val[NEXT-1:0] = falling_edge_enable_reg_ff;
      `RIC_OFS_KEY_EN:   rd_val[NKEY-1:0] = key_enable_ff;
      `RIC_OFS_CTRL:     rd_val[0]        = glob_en_ff;
      `RIC_OFS_CAUSE:    rd_val[`RIC_CAUSE_W-1:0] = cause_ff;
      `RIC_OFS_CAUSE_EN: rd_val[`RIC_CAUSE_W-1:0] = cause_en_ff;
      `RIC_OFS_STATUS:   rd_val[12:0] = {svc_level_ff, svc_vector_ff, isr_ff,
                                         state_ff, sys_reset_ff, found};
      default:           rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `RIC_RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `RIC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awaddr_ff  <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (s_axi_wvalid && wready_ff) begin
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_ok ? `RIC_RESP_OKAY : `RIC_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
      if (do_rd) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_val;
        rresp_ff   <= rd_ok ? `RIC_RESP_OKAY : `RIC_RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  wire wr_at_flag  = do_wr && awaddr_ff == `RIC_OFS_FLAG;
  wire rd_at_cause = do_rd && s_axi_araddr == `RIC_OFS_CAUSE;

  always @(posedge aclk) begin
    if (!aresetn) begin
      request_flag_bit_ff        <= {N{1'b0}};
      source_mask_bit_ff         <= `RIC_RST_MASK;
      priority_low_bit_ff        <= `RIC_RST_PRIO;
      priority_high_bit_ff       <= `RIC_RST_PRIO;
      rising_edge_enable_reg_ff  <= {NEXT{1'b0}};
      falling_edge_enable_reg_ff <= {NEXT{1'b0}};
      key_enable_ff              <= `RIC_RST_EDGE;
      glob_en_ff                 <= `RIC_RST_CTRL;
      cause_ff                   <= {`RIC_CAUSE_W{1'b0}};
      cause_en_ff                <= {`RIC_CAUSE_W{1'b0}};
      irq_ff                     <= 1'b0;
    end else begin
      // write-one clears; events set even when masked
      request_flag_bit_ff <= (request_flag_bit_ff &
                              ~(wr_at_flag ? wbits[N-1:0] : {N{1'b0}}) &
                              ~ack_clr) | evt;
      // cause is sticky, read clears, new hit wins
      cause_ff <= (rd_at_cause ? {`RIC_CAUSE_W{1'b0}} : cause_ff) | cause_hit;
      irq_ff   <= |(cause_ff & cause_en_ff);
      if (do_wr) begin
        case (awaddr_ff)
          `RIC_OFS_MASK: source_mask_bit_ff <=
            (source_mask_bit_ff & ~bmask[N-1:0]) | wbits[N-1:0];
          `RIC_OFS_PRIO_LO: priority_low_bit_ff <=
            (priority_low_bit_ff & ~bmask[N-1:0]) | wbits[N-1:0];
          `RIC_OFS_PRIO_HI: priority_high_bit_ff <=
            (priority_high_bit_ff & ~bmask[N-1:0]) | wbits[N-1:0];
          `RIC_OFS_RISE: rising_edge_enable_reg_ff <=
            (rising_edge_enable_reg_ff & ~bmask[NEXT-1:0]) | wbits[NEXT-1:0];
          `RIC_OFS_FALL: falling_edge_enable_reg_ff <=
            (falling_edge_enable_reg_ff & ~bmask[NEXT-1:0]) | wbits[NEXT-1:0];
          `RIC_OFS_KEY_EN: key_enable_ff <=
            (key_enable_ff & ~bmask[NKEY-1:0]) | wbits[NKEY-1:0];
          `RIC_OFS_CTRL: if (wstrb_ff[0]) glob_en_ff <= wdata_ff[0];
          `RIC_OFS_CAUSE_EN: if (wstrb_ff[0]) cause_en_ff <=
            wdata_ff[`RIC_CAUSE_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;
  assign sys_reset     = sys_reset_ff;
  assign svc_start     = svc_start_ff;
  assign svc_vector    = svc_vector_ff;
  assign svc_level     = svc_level_ff;
  assign irq           = irq_ff;

endmodule

`default_nettype wire

// ==== ric_top_sva.sv ====
// Purpose: port-level checks of the reset and interrupt controller
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to ric_top below
`timescale 1ns/1ns
`default_nettype none

module ric_top_sva (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // reset causes
  input wire logic        reset_pin_n,
  input wire logic        wdt_loop,
  input wire logic        por_detect,
  input wire logic        voltage_detector,
  input wire logic        opcode_fetch,
  input wire logic [7:0]  opcode,
  input wire logic        emu_active,
  input wire logic        ram_read,
  input wire logic        ram_parity_err,
  input wire logic        illegal_access,
  // outputs watched, plus the rready input
  input wire logic        sys_reset,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire illop_w = opcode_fetch && opcode == 8'hFF;
  wire quiet_w = !wdt_loop && !por_detect && !voltage_detector
                 && !(ram_read && ram_parity_err) && !illegal_access;

  // ----------------------------------------
  // reset causes
  // ----------------------------------------
  // pin passes a 3-flop filter first, so allow it six edges
  pin_rst_a: assert property (
    !reset_pin_n [*6] |=> sys_reset) else $error("pin low without reset");
  wdt_rst_a: assert property (
    wdt_loop |=> sys_reset [*2]) else $error("watchdog reset too short");
  volt_rst_a: assert property (
    por_detect || voltage_detector |=> sys_reset) else $error("supply drop ignored");
  illop_rst_a: assert property (
    illop_w && !emu_active |=> sys_reset) else $error("illegal opcode ignored");
  emu_sup_a: assert property (
    reset_pin_n [*6] ##0 (illop_w && emu_active && quiet_w && !sys_reset)
    |=> !sys_reset) else $error("reset under emulation");
  parity_rst_a: assert property (
    ram_read && ram_parity_err |=> sys_reset) else $error("parity error ignored");
  access_rst_a: assert property (
    illegal_access |=> sys_reset) else $error("bad access ignored");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind ric_top ric_top_sva i_sva (
  .aclk, .aresetn, .reset_pin_n, .wdt_loop, .por_detect, .voltage_detector,
  .opcode_fetch, .opcode, .emu_active, .ram_read, .ram_parity_err,
  .illegal_access, .sys_reset, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata
);
`default_nettype wire

// ==== ric_cpu_model.sv ====
// Purpose: cpu core stand-in that ends each service after a delay
// Assumes: one return pulse per started service
// Notes:   slow on purpose so nesting can be exercised
`timescale 1ns/1ns
`default_nettype none

module ric_cpu_model #(
  parameter int DLY = 30
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // service handshake
  input wire logic svc_start,
  output var logic cpu_reti
);
  int depth_ff;
  int cnt_ff;

  always @(posedge aclk) begin
    if (!aresetn) begin
      depth_ff <= 0;
      cnt_ff <= 0;
      cpu_reti <= 1'b0;
    end else begin
      cpu_reti <= 1'b0;
      if (svc_start) begin
        depth_ff <= depth_ff + 1;
        cnt_ff <= 0;
      end else if (depth_ff > 0 && cnt_ff == DLY) begin
        cpu_reti <= 1'b1;
        depth_ff <= depth_ff - 1;
        cnt_ff <= 0;
      end else begin
        cnt_ff <= cnt_ff + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_ric_top.sv ====
// Purpose: self-checking bench for the reset and interrupt controller
// Assumes: 50 MHz aclk, reset hold shortened to 2 cycles
// Notes:   cpu side answered by ric_cpu_model
`timescale 1ns/1ns
`default_nettype none

module tb_ric_top;
  typedef struct {logic [7:0] v; logic [7:0] op; logic [5:0] c;} ric_row_t;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, reset_pin_n = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [7:0]  cz = 8'h00, opcode = 8'h00, key_pin = 8'hFF;
  logic [5:0]  ext_int_pin = 6'h02;
  logic [8:0]  int_src = 9'h000;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]   s_axi_bresp, s_axi_rresp, svc_level;
  wire [31:0]  s_axi_rdata;
  wire         cpu_reti, sys_reset, svc_start, irq;
  wire [3:0]   svc_vector;
  int          error_cnt = 0;
  int          check_count = 0;
  // cause inputs {wdt,por,volt,fetch,emu,ram_read,parity,access}
  ric_row_t    rows [9] = '{
    '{8'h80, 8'h00, 6'h02}, '{8'h40, 8'h00, 6'h04}, '{8'h20, 8'h00, 6'h04},
    '{8'h10, 8'hFF, 6'h08}, '{8'h18, 8'hFF, 6'h00}, '{8'h10, 8'hFE, 6'h00},
    '{8'h06, 8'h00, 6'h10}, '{8'h02, 8'h00, 6'h00}, '{8'h01, 8'h00, 6'h20}};

  always #10 aclk = ~aclk;

  ric_top #(.RST_HOLD(2)) i_dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .reset_pin_n, .wdt_loop(cz[7]),
    .por_detect(cz[6]), .voltage_detector(cz[5]), .opcode_fetch(cz[4]),
    .opcode, .emu_active(cz[3]), .ram_read(cz[2]), .ram_parity_err(cz[1]),
    .illegal_access(cz[0]), .ext_int_pin, .key_pin, .int_src, .cpu_reti,
    .sys_reset, .svc_start, .svc_vector, .svc_level, .irq);

  ric_cpu_model i_cpu (.aclk, .aresetn, .svc_start, .cpu_reti);

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      $display("ERROR %0t: no bus answer", $time);
      end_of_test;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    logic ad = 1'b0;
    logic dd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !dd) begin
        dd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(ad && dd) && n < 200);
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 200);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 200);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 200);
    // ready raised late so read data must stand a cycle
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rdata, e);
    chk(s_axi_rresp, er);
  endtask

  task automatic wsvc(input int lim, output int n);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!svc_start && n < lim);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int n;
    cyc(4);
    aresetn <= 1'b1;
    cyc(1);
    rd(8'h04, 32'h0000FFFF, 2'h0);
    rd(8'h08, 32'h0000FFFF, 2'h0);
    rd(8'h30, 32'h0, 2'h2);
    wr(8'h20, 32'h1, 2'h2);
    wr(8'h24, 32'h3F, 2'h0);
    foreach (rows[i]) begin
      cz <= rows[i].v;
      opcode <= rows[i].op;
      cyc(1);
      cz <= 8'h00;
      @(negedge aclk);
      chk(sys_reset, |rows[i].c);
      cyc(8);
      chk(irq, |rows[i].c);
      chk(sys_reset, 1'b0);
      rd(8'h20, rows[i].c, 2'h0);
      cyc(2);
      chk(irq, 1'b0);
    end
    reset_pin_n <= 1'b0;
    cyc(8);
    reset_pin_n <= 1'b1;
    chk(sys_reset, 1'b1);
    cyc(12);
    rd(8'h20, 32'h1, 2'h0);
    // cause masked keeps irq low
    wr(8'h24, 32'h0, 2'h0);
    cz <= 8'h80;
    cyc(1);
    cz <= 8'h00;
    cyc(6);
    chk(irq, 1'b0);
    rd(8'h20, 32'h2, 2'h0);
    wr(8'h10, 32'h1, 2'h0);
    wr(8'h14, 32'h2, 2'h0);
    wr(8'h18, 32'h1, 2'h0);
    ext_int_pin <= 6'h05;
    key_pin <= 8'hFE;
    cyc(8);
    rd(8'h00, 32'h43, 2'h0);
    wr(8'h00, 32'hFFFF, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    wr(8'h0C, 32'hFDFF, 2'h0);
    wr(8'h08, 32'hFC7F, 2'h0);
    wr(8'h04, 32'hFC7F, 2'h0);
    wr(8'h1C, 32'h1, 2'h0);
    int_src <= 9'h003;
    cyc(1);
    int_src <= 9'h000;
    wsvc(40, n);
    chk(n >= 10 && n <= 17, 1'b1);
    chk({svc_vector, svc_level}, 6'h1E);
    cyc(1);
    int_src <= 9'h004;
    cyc(1);
    int_src <= 9'h000;
    wsvc(40, n);
    chk({svc_vector, svc_level}, 6'h24);
    wsvc(200, n);
    chk({svc_vector, svc_level}, 6'h22);
    cyc(40);
    int_src <= 9'h008;
    cyc(1);
    int_src <= 9'h000;
    wsvc(40, n);
    chk(n, 40);
    cyc(1);
    rd(8'h00, 32'h400, 2'h0);
    wr(8'h04, 32'hF87F, 2'h0);
    wsvc(40, n);
    chk({svc_vector, svc_level}, 6'h2B);
    cyc(1);
    rd(8'h28, 32'h1D40, 2'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
